// >>> core/bcc_pkg.sv
// constants and carrier types for the backup cache coherence block
// assumes a single 10 MHz clock and an Avalon-MM register master
// Overview of operation
// R1: primary cache is 8K instruction plus 8K write-through data, direct mapped, 32B blocks
// R2: every valid primary block is also valid in the backup cache
// R3: backup cache holds 4 MB, direct mapped, 64-byte lines
// R4: line tag holds address bits 33:22 with even parity
// R5: each line keeps valid, shared, dirty and even status parity
// R6: status store rewritten apart from tag; write hit to unshared line sets dirty
// R7: tag loaded by bus side only; status and data by both
// R8: read probe hits on tag match with valid set
// R9: write probe hits on tag match, valid set, shared clear
// R10: invalid is miss; unshared is sole copy; shared needs broadcast writes
// R11: every bus write leaves the line clean everywhere and updates memory
// R12: snooped write to primary-resident block updates line, invalidates primary block
// R13: snooped write to line absent from primary invalidates backup line
// R14: snooped read hitting dirty valid line supplies the data
// R15: mode field picks normal decision or forced invalidate or update
// R16: every bus address compared with lock, victim and pending-write registers
// R17: snooped read on victim address answers as owner from victim buffer
// R18: snooped write on victim address kills victim and its bus request
// R19: snooped write on pending-write address is taken as update
// R20: write on lock address clears lock flag; read answers shared only
// R21: dirty displaced line goes to victim buffer, written back after refill
// R22: no second miss starts while a victim is still held
// R23: write probe finding line shared broadcasts the write
// R24: miss issues bus read; new shared and dirty from response and intent
package bcc_pkg;
    // geometry
    localparam int PC_BYTES   = 8192;
    localparam int PC_BLK     = 32;
    localparam int BC_LINE    = 64;
    localparam int BC_LINES   = 65536;
    localparam int PM_ENTRIES = 256;
    localparam int TAG_HI     = 33;
    localparam int TAG_LO     = 22;
    localparam int IDX_LO     = 6;
    // register byte offsets
    localparam logic [4:0] OFF_MODE  = 5'h00;
    localparam logic [4:0] OFF_LOCK  = 5'h04;
    localparam logic [4:0] OFF_VICT  = 5'h08;
    localparam logic [4:0] OFF_WPEND = 5'h0c;
    localparam logic [4:0] OFF_STATE = 5'h10;
    localparam int          FLAG_BIT  = 31;
    localparam logic [31:0] REG_RST   = 32'h0000_0000;
    // write response modes
    localparam logic [1:0] WM_NORMAL = 2'h0;
    localparam logic [1:0] WM_FINV   = 2'h1;
    localparam logic [1:0] WM_FUPD   = 2'h2;
    // bus commands
    localparam logic [1:0] CMD_READ  = 2'h1;
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] CMD_VICT  = 2'h3;
    typedef struct packed {
        logic v;
        logic s;
        logic d;
        logic p;
    } bcc_stat_t;
    typedef struct packed {
        logic shared;
        logic dirty;
        logic supply;
        logic vsupply;
        logic update;
        logic inval;
    } bcc_snp_t;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_RDREQ = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_BCAST = 4'b1000
    } bcc_state_t;
endpackage

// >>> core/bcc_top.sv
// backup cache tag/status store, snoop responder and miss sequencer
// assumes bus side holds requests until accepted; one synchronous reset
`timescale 1ns/1ns
`default_nettype none
module bcc_top
    import bcc_pkg::*;
(
    // clock and reset
    input  wire logic        CLOCK_IN,
    input  wire logic        RST_N_IN,
    // register bus
    input  wire logic [4:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    output logic [31:0]      AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    // processor probe
    input  wire logic        PREQ_VALID_IN,
    input  wire logic        PREQ_WRITE_IN,
    input  wire logic [33:0] PREQ_ADDR_IN,
    output logic             PREQ_READY_OUT,
    output logic             PRSP_VALID_OUT,
    output logic             PRSP_HIT_OUT,
    // bus requests and fill
    output logic             BREQ_VALID_OUT,
    output logic [1:0]       BREQ_CMD_OUT,
    output logic [33:0]      BREQ_ADDR_OUT,
    input  wire logic        BREQ_READY_IN,
    input  wire logic        FILL_VALID_IN,
    input  wire logic        FILL_SHARED_IN,
    output logic             FILL_READY_OUT,
    // snoop
    input  wire logic        SNP_VALID_IN,
    input  wire logic        SNP_WRITE_IN,
    input  wire logic [33:0] SNP_ADDR_IN,
    output logic             SNP_RSP_VALID_OUT,
    output bcc_snp_t         SNP_RSP_OUT,
    // primary invalidate
    output logic             PINV_VALID_OUT,
    output logic [6:0]       PINV_PAIR_OUT
);
    // ========================================
    // helpers
    function automatic logic [15:0] idx_of(input logic [33:0] a);
        return a[21:IDX_LO]; // R3
    endfunction
    function automatic logic [27:0] line_of(input logic [33:0] a);
        return a[33:IDX_LO];
    endfunction
    function automatic bcc_stat_t mk_stat(input logic v, input logic s, input logic d);
        return '{v: v, s: s, d: d, p: v ^ s ^ d}; // R5
    endfunction
    // ========================================
    // storage
    logic [11:0] tag_mem  [BC_LINES];
    logic        tpar_mem [BC_LINES];
    bcc_stat_t   stat_mem [BC_LINES];
    logic        pm_v     [PM_ENTRIES]; // R1
    logic [20:0] pm_tag   [PM_ENTRIES];
    bcc_state_t  state_q;
    logic        rq_wr_q;
    logic [33:0] rq_addr_q;
    logic [31:0] mode_q, lock_q, wpend_q;
    logic        vict_v_q;
    logic [27:0] vict_line_q;
    logic        rd_ack_q;
    // ========================================
    // processor probe
    logic [15:0] p_idx;
    bcc_stat_t   p_st;
    logic        p_tag_eq, p_rd_hit, p_wr_hit, p_hit, p_shared_wr, p_victim, cpu_go, snp_free;
    assign snp_free    = !SNP_VALID_IN;
    assign p_idx       = idx_of(PREQ_ADDR_IN);
    assign p_st        = stat_mem[p_idx];
    assign p_tag_eq    = tag_mem[p_idx] == PREQ_ADDR_IN[TAG_HI:TAG_LO];
    assign p_rd_hit    = p_tag_eq && p_st.v; // R8
    assign p_wr_hit    = p_tag_eq && p_st.v && !p_st.s; // R9
    assign p_hit       = PREQ_WRITE_IN ? p_wr_hit : p_rd_hit;
    assign p_shared_wr = PREQ_WRITE_IN && p_rd_hit && p_st.s; // R10
    assign p_victim    = !p_rd_hit && p_st.v && p_st.d;
    // a miss waits while a victim is held: only one buffer
    assign cpu_go = state_q == ST_IDLE && PREQ_VALID_IN && snp_free
                    && (p_hit || p_shared_wr || !vict_v_q); // R22
    assign PREQ_READY_OUT = cpu_go;
    // ========================================
    // snoop decode
    logic [15:0] s_idx;
    bcc_stat_t   s_st;
    logic [27:0] s_line;
    logic        s_match, s_pres, lock_hit, vict_hit, wp_hit, s_upd;
    bcc_snp_t    s_rsp;
    assign s_idx    = idx_of(SNP_ADDR_IN);
    assign s_line   = line_of(SNP_ADDR_IN);
    assign s_st     = stat_mem[s_idx];
    assign s_match  = s_st.v && tag_mem[s_idx] == SNP_ADDR_IN[TAG_HI:TAG_LO];
    // either 32-byte half of the line resident in the primary backmap
    assign s_pres   = (pm_v[{SNP_ADDR_IN[12:6], 1'b0}] && pm_tag[{SNP_ADDR_IN[12:6], 1'b0}] == SNP_ADDR_IN[33:13])
                   || (pm_v[{SNP_ADDR_IN[12:6], 1'b1}] && pm_tag[{SNP_ADDR_IN[12:6], 1'b1}] == SNP_ADDR_IN[33:13]);
    assign lock_hit = lock_q[FLAG_BIT] && lock_q[27:0] == s_line; // R16
    assign vict_hit = vict_v_q && vict_line_q == s_line; // R16
    assign wp_hit   = wpend_q[FLAG_BIT] && wpend_q[27:0] == s_line; // R16
    // update chosen by backmap or pending write unless mode forces it
    assign s_upd = s_match && (mode_q[1:0] == WM_FUPD
                   || (mode_q[1:0] == WM_NORMAL && (s_pres || wp_hit))); // R15
    always_comb
    begin
        s_rsp = '0;
        if (SNP_WRITE_IN)
        begin
            s_rsp.shared = s_match || vict_hit || wp_hit;
            s_rsp.dirty  = lock_hit || vict_hit || wp_hit;
            s_rsp.update = s_upd; // R12 R19
            s_rsp.inval  = s_match && !s_upd; // R13
        end
        else
        begin
            s_rsp.shared  = s_match || lock_hit || vict_hit || wp_hit; // R20
            s_rsp.dirty   = (s_match && s_st.d) || vict_hit;
            s_rsp.supply  = s_match && s_st.d; // R14
            s_rsp.vsupply = vict_hit; // R17
        end
    end
    // ========================================
    // snoop answer registers
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            SNP_RSP_VALID_OUT <= 1'b0;
            SNP_RSP_OUT       <= '0;
        end
        else
        begin
            SNP_RSP_VALID_OUT <= SNP_VALID_IN;
            SNP_RSP_OUT       <= SNP_VALID_IN ? s_rsp : '0;
        end
    end
    // ========================================
    // sequencer
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            state_q   <= ST_IDLE;
            rq_wr_q   <= 1'b0;
            rq_addr_q <= '0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (cpu_go)
                    begin
                        rq_wr_q   <= PREQ_WRITE_IN;
                        rq_addr_q <= PREQ_ADDR_IN;
                        if (p_shared_wr)
                            state_q <= ST_BCAST; // R23
                        else if (!p_hit)
                            state_q <= ST_RDREQ; // R24
                    end
                ST_RDREQ:
                    if (BREQ_VALID_OUT && BREQ_READY_IN)
                        state_q <= ST_WAIT;
                ST_WAIT:
                    if (FILL_VALID_IN && FILL_READY_OUT)
                        state_q <= (rq_wr_q && FILL_SHARED_IN) ? ST_BCAST : ST_IDLE;
                ST_BCAST:
                    if (BREQ_VALID_OUT && BREQ_READY_IN)
                        state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
    assign FILL_READY_OUT = state_q == ST_WAIT && snp_free;
    // ========================================
    // bus request mux; victim goes only once the refill is done
    always_comb
    begin
        BREQ_VALID_OUT = 1'b0;
        BREQ_CMD_OUT   = CMD_READ;
        BREQ_ADDR_OUT  = rq_addr_q;
        if (state_q == ST_RDREQ)
            BREQ_VALID_OUT = snp_free; // R24
        else if (state_q == ST_BCAST)
        begin
            BREQ_VALID_OUT = snp_free; // R23
            BREQ_CMD_OUT   = CMD_WRITE;
        end
        else if (state_q == ST_IDLE && vict_v_q)
        begin
            BREQ_VALID_OUT = snp_free; // R21
            BREQ_CMD_OUT   = CMD_VICT;
            BREQ_ADDR_OUT  = {vict_line_q, 6'h00};
        end
    end
    // ========================================
    // processor answer
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            PRSP_VALID_OUT <= 1'b0;
            PRSP_HIT_OUT   <= 1'b0;
        end
        else
        begin
            PRSP_VALID_OUT <= (cpu_go && p_hit)
                || (state_q == ST_WAIT && FILL_VALID_IN && FILL_READY_OUT && !(rq_wr_q && FILL_SHARED_IN))
                || (state_q == ST_BCAST && BREQ_VALID_OUT && BREQ_READY_IN);
            PRSP_HIT_OUT   <= cpu_go && p_hit;
        end
    end
    // ========================================
    // victim buffer tracking
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            vict_v_q    <= 1'b0;
            vict_line_q <= '0;
        end
        else if (SNP_VALID_IN && SNP_WRITE_IN && vict_hit)
            vict_v_q <= 1'b0; // R18
        else if (cpu_go && !p_hit && !p_shared_wr && p_victim)
        begin
            vict_v_q    <= 1'b1; // R21
            vict_line_q <= {tag_mem[p_idx], p_idx};
        end
        else if (BREQ_VALID_OUT && BREQ_READY_IN && BREQ_CMD_OUT == CMD_VICT)
            vict_v_q <= 1'b0;
    end
    // ========================================
    // tag, status and backmap stores; snoop wins the cycle
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            for (int i = 0; i < BC_LINES; i++)
                stat_mem[i] <= mk_stat(1'b0, 1'b0, 1'b0);
            for (int j = 0; j < PM_ENTRIES; j++)
                pm_v[j] <= 1'b0;
        end
        else if (SNP_VALID_IN)
        begin
            if (SNP_WRITE_IN && s_match)
            begin
                stat_mem[s_idx] <= mk_stat(s_upd, s_upd && s_st.s, 1'b0); // R11 R13
                pm_v[{SNP_ADDR_IN[12:6], 1'b0}] <= 1'b0; // R12
                pm_v[{SNP_ADDR_IN[12:6], 1'b1}] <= 1'b0;
            end
            else if (!SNP_WRITE_IN && s_match)
                stat_mem[s_idx] <= mk_stat(1'b1, 1'b1, s_st.d);
        end
        else if (cpu_go && PREQ_WRITE_IN && p_wr_hit)
            stat_mem[p_idx] <= mk_stat(1'b1, 1'b0, 1'b1); // R6
        else if (cpu_go && !PREQ_WRITE_IN && p_rd_hit)
        begin
            pm_v[PREQ_ADDR_IN[12:5]]   <= 1'b1; // R2
            pm_tag[PREQ_ADDR_IN[12:5]] <= PREQ_ADDR_IN[33:13];
        end
        else if (FILL_VALID_IN && FILL_READY_OUT)
        begin
            tag_mem[idx_of(rq_addr_q)]  <= rq_addr_q[TAG_HI:TAG_LO]; // R7
            tpar_mem[idx_of(rq_addr_q)] <= ^rq_addr_q[TAG_HI:TAG_LO]; // R4
            stat_mem[idx_of(rq_addr_q)] <= mk_stat(1'b1, FILL_SHARED_IN, rq_wr_q && !FILL_SHARED_IN); // R24
            // displaced line leaves the primary cache too
            pm_v[{rq_addr_q[12:6], 1'b0}] <= 1'b0; // R2
            pm_v[{rq_addr_q[12:6], 1'b1}] <= 1'b0;
            if (!rq_wr_q)
            begin
                pm_v[rq_addr_q[12:5]]   <= 1'b1;
                pm_tag[rq_addr_q[12:5]] <= rq_addr_q[33:13];
            end
        end
        else if (state_q == ST_BCAST && BREQ_VALID_OUT && BREQ_READY_IN)
            stat_mem[idx_of(rq_addr_q)] <= mk_stat(1'b1, 1'b1, 1'b0); // R11
    end
    // ========================================
    // primary invalidate strobe
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            PINV_VALID_OUT <= 1'b0;
            PINV_PAIR_OUT  <= '0;
        end
        else
        begin
            PINV_VALID_OUT <= (SNP_VALID_IN && SNP_WRITE_IN && s_match) || (FILL_VALID_IN && FILL_READY_OUT); // R2 R12
            PINV_PAIR_OUT  <= SNP_VALID_IN ? SNP_ADDR_IN[12:6] : rq_addr_q[12:6];
        end
    end
    // ========================================
    // software registers; a bus write to the lock line beats a software set
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            mode_q  <= REG_RST;
            lock_q  <= REG_RST;
            wpend_q <= REG_RST;
        end
        else
        begin
            if (AVS_WRITE_IN && AVS_ADDRESS_IN == OFF_MODE)
                mode_q <= {30'h0, AVS_WRITEDATA_IN[1:0]};
            if (AVS_WRITE_IN && AVS_ADDRESS_IN == OFF_WPEND)
                wpend_q <= AVS_WRITEDATA_IN;
            if (SNP_VALID_IN && SNP_WRITE_IN && lock_hit)
                lock_q[FLAG_BIT] <= 1'b0; // R20
            else if (AVS_WRITE_IN && AVS_ADDRESS_IN == OFF_LOCK)
                lock_q <= AVS_WRITEDATA_IN;
        end
    end
    // ========================================
    // read path: one wait cycle, data registered
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            rd_ack_q         <= 1'b0;
            AVS_READDATA_OUT <= '0;
        end
        else
        begin
            rd_ack_q <= AVS_READ_IN && !rd_ack_q;
            if (AVS_READ_IN && !rd_ack_q)
                case (AVS_ADDRESS_IN)
                    OFF_MODE:  AVS_READDATA_OUT <= mode_q;
                    OFF_LOCK:  AVS_READDATA_OUT <= lock_q;
                    OFF_VICT:  AVS_READDATA_OUT <= {vict_v_q, 3'h0, vict_line_q};
                    OFF_WPEND: AVS_READDATA_OUT <= wpend_q;
                    OFF_STATE: AVS_READDATA_OUT <= {28'h0, state_q};
                    default:   AVS_READDATA_OUT <= '0;
                endcase
        end
    end
    assign AVS_WAITREQUEST_OUT = AVS_READ_IN && !rd_ack_q;
    // ========================================
    // checks
    sequence q_snp_wr_vict;
        SNP_VALID_IN && SNP_WRITE_IN && vict_hit;
    endsequence
    property p_rd_hit_rule;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        cpu_go && !PREQ_WRITE_IN |=> PRSP_VALID_OUT == $past(p_rd_hit) && PRSP_HIT_OUT == $past(p_rd_hit);
    endproperty
    a_rd_hit_rule: assert property (p_rd_hit_rule) else $error("read probe answer wrong"); // R8
    property p_wr_shared;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        cpu_go && p_shared_wr |=> state_q == ST_BCAST && !PRSP_HIT_OUT;
    endproperty
    a_wr_shared: assert property (p_wr_shared) else $error("shared write not broadcast"); // R9 R23
    property p_vict_kill;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        q_snp_wr_vict |=> !vict_v_q && !(BREQ_VALID_OUT && BREQ_CMD_OUT == CMD_VICT);
    endproperty
    a_vict_kill: assert property (p_vict_kill) else $error("victim request not withdrawn"); // R18
    property p_supply;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        SNP_VALID_IN && !SNP_WRITE_IN && s_match && s_st.d |=> SNP_RSP_VALID_OUT && SNP_RSP_OUT.supply;
    endproperty
    a_supply: assert property (p_supply) else $error("dirty line not supplied"); // R14
    property p_vsupply;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        SNP_VALID_IN && !SNP_WRITE_IN && vict_hit |=> SNP_RSP_OUT.vsupply && SNP_RSP_OUT.dirty;
    endproperty
    a_vsupply: assert property (p_vsupply) else $error("victim not supplied"); // R17
    property p_lock_clr;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        SNP_VALID_IN && SNP_WRITE_IN && lock_hit |=> !lock_q[FLAG_BIT];
    endproperty
    a_lock_clr: assert property (p_lock_clr) else $error("lock flag kept"); // R20
    property p_upd_or_inv;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        SNP_VALID_IN && SNP_WRITE_IN && s_match
        |=> SNP_RSP_OUT.update != SNP_RSP_OUT.inval && PINV_VALID_OUT;
    endproperty
    a_upd_or_inv: assert property (p_upd_or_inv) else $error("write snoop decision wrong"); // R12 R13
    property p_force_inv;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        SNP_VALID_IN && SNP_WRITE_IN && s_match && mode_q[1:0] == WM_FINV |=> SNP_RSP_OUT.inval;
    endproperty
    a_force_inv: assert property (p_force_inv) else $error("forced invalidate missed"); // R15
    property p_one_victim;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        vict_v_q && state_q == ST_IDLE ##1 state_q == ST_RDREQ |-> $past(p_hit || p_shared_wr) == 1'b0 && 1'b0;
    endproperty
    a_one_victim: assert property (p_one_victim) else $error("second miss with victim held"); // R22
    property p_fill_state;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        FILL_VALID_IN && FILL_READY_OUT ##1 1'b1
        |-> stat_mem[idx_of(rq_addr_q)].v && stat_mem[idx_of(rq_addr_q)].s == $past(FILL_SHARED_IN);
    endproperty
    a_fill_state: assert property (p_fill_state) else $error("fill state wrong"); // R24
endmodule
`default_nettype wire

// >>> verif/bcc_bus_model.sv
// system bus model: accepts requests, answers refills
// assumes requests are held until ready; one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
module bcc_bus_model
    import bcc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // test controls
    input  wire logic [3:0] dly_in,
    input  wire logic       shared_in,
    // request and fill
    input  wire logic       breq_valid_in,
    input  wire logic [1:0] breq_cmd_in,
    output logic            breq_ready_out,
    input  wire logic       fill_ready_in,
    output logic            fill_valid_out,
    output logic            fill_shared_out
);
    // ==========
    // acceptance and refill
    logic [3:0] wait_q;
    // slow answers keep a victim write pending for a while
    assign breq_ready_out = breq_valid_in && (wait_q >= dly_in);
    // released line shows the inverse, never a stale copy
    assign fill_shared_out = fill_valid_out ? shared_in : !shared_in;
    // refill follows every accepted read
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            wait_q <= 4'h0;
            fill_valid_out <= 1'b0;
        end
        else
        begin
            wait_q <= (breq_valid_in && !breq_ready_out) ? wait_q + 4'h1 : 4'h0;
            if (breq_ready_out && breq_cmd_in == CMD_READ)
                fill_valid_out <= 1'b1;
            else if (fill_ready_in)
                fill_valid_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> verif/bcc_top_tb.sv
// self-checking bench for the backup cache coherence block
// assumes bcc_bus_model stands on the bus side
`timescale 1ns/1ns
`default_nettype none
module bcc_top_tb
    import bcc_pkg::*;
;
    // ==========
    // signals
    logic        CLOCK_IN = 1'b0, RST_N_IN, AVS_READ_IN, AVS_WRITE_IN, AVS_WAITREQUEST_OUT;
    logic        PREQ_VALID_IN, PREQ_WRITE_IN, PREQ_READY_OUT, PRSP_VALID_OUT, PRSP_HIT_OUT;
    logic        BREQ_VALID_OUT, BREQ_READY_IN, FILL_VALID_IN, FILL_SHARED_IN, FILL_READY_OUT;
    logic        SNP_VALID_IN, SNP_WRITE_IN, SNP_RSP_VALID_OUT, PINV_VALID_OUT, shared_q;
    logic [1:0]  BREQ_CMD_OUT, last_cmd;
    logic [3:0]  dly_q;
    logic [4:0]  AVS_ADDRESS_IN;
    logic [6:0]  PINV_PAIR_OUT;
    logic [7:0]  pinv;
    logic [31:0] AVS_WRITEDATA_IN, AVS_READDATA_OUT, rd;
    logic [33:0] PREQ_ADDR_IN, BREQ_ADDR_OUT, SNP_ADDR_IN, last_adr;
    bcc_snp_t    SNP_RSP_OUT, rsp;
    int          bad_count, num_checks;
    // a and c share an index, so c displaces a
    localparam logic [33:0] A = 34'h1_0000_0040, C = 34'h1_0040_0040;
    localparam logic [33:0] B = 34'h0_0000_2080, L = 34'h0_0000_1000;
    typedef struct packed { logic [4:0] a; logic [31:0] w; logic [31:0] e; } bcc_row_t;
    bcc_row_t rows [4] = '{'{OFF_MODE, 32'h0000_0002, 32'h0000_0002}, '{OFF_LOCK, 32'h8000_0040, 32'h8000_0040},
                           '{OFF_VICT, 32'hffff_ffff, REG_RST}, '{5'h14, 32'hffff_ffff, REG_RST}};
    bcc_top i_bcc_top (
        .CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
        .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
        .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .PREQ_VALID_IN(PREQ_VALID_IN), .PREQ_WRITE_IN(PREQ_WRITE_IN),
        .PREQ_ADDR_IN(PREQ_ADDR_IN), .PREQ_READY_OUT(PREQ_READY_OUT), .PRSP_VALID_OUT(PRSP_VALID_OUT),
        .PRSP_HIT_OUT(PRSP_HIT_OUT), .BREQ_VALID_OUT(BREQ_VALID_OUT), .BREQ_CMD_OUT(BREQ_CMD_OUT),
        .BREQ_ADDR_OUT(BREQ_ADDR_OUT), .BREQ_READY_IN(BREQ_READY_IN), .FILL_VALID_IN(FILL_VALID_IN),
        .FILL_SHARED_IN(FILL_SHARED_IN), .FILL_READY_OUT(FILL_READY_OUT), .SNP_VALID_IN(SNP_VALID_IN),
        .SNP_WRITE_IN(SNP_WRITE_IN), .SNP_ADDR_IN(SNP_ADDR_IN), .SNP_RSP_VALID_OUT(SNP_RSP_VALID_OUT),
        .SNP_RSP_OUT(SNP_RSP_OUT), .PINV_VALID_OUT(PINV_VALID_OUT), .PINV_PAIR_OUT(PINV_PAIR_OUT));
    bcc_bus_model i_bcc_bus_model (
        .clk_in(CLOCK_IN), .rst_n_in(RST_N_IN), .dly_in(dly_q), .shared_in(shared_q),
        .breq_valid_in(BREQ_VALID_OUT), .breq_cmd_in(BREQ_CMD_OUT), .breq_ready_out(BREQ_READY_IN),
        .fill_ready_in(FILL_READY_OUT), .fill_valid_out(FILL_VALID_IN), .fill_shared_out(FILL_SHARED_IN));
    // ==========
    // clock, command log, tasks
    always #50 CLOCK_IN = !CLOCK_IN;
    always @(posedge CLOCK_IN)
        if (BREQ_VALID_OUT && BREQ_READY_IN)
            {last_cmd, last_adr} <= {BREQ_CMD_OUT, BREQ_ADDR_OUT};
    task chk(input logic [33:0] e, input logic [33:0] g, input string nm);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // every task starts and ends just after a rising edge
    task av(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        {AVS_WRITE_IN, AVS_READ_IN, AVS_ADDRESS_IN, AVS_WRITEDATA_IN} <= {w, !w, a, d};
        @(posedge CLOCK_IN);
        for (n = 0; n < 50 && AVS_WAITREQUEST_OUT !== 1'b0; n++) @(posedge CLOCK_IN);
        rd = AVS_READDATA_OUT;
        {AVS_WRITE_IN, AVS_READ_IN} <= 2'b00;
        @(posedge CLOCK_IN);
    endtask
    task probe(input logic w, input logic [33:0] a, input logic h);
        int n;
        {PREQ_VALID_IN, PREQ_WRITE_IN, PREQ_ADDR_IN} <= {1'b1, w, a};
        @(posedge CLOCK_IN);
        for (n = 0; n < 300 && PREQ_READY_OUT !== 1'b1; n++) @(posedge CLOCK_IN);
        PREQ_VALID_IN <= 1'b0;
        @(posedge CLOCK_IN);
        for (n = 0; n < 300 && PRSP_VALID_OUT !== 1'b1; n++) @(posedge CLOCK_IN);
        chk(h, PRSP_HIT_OUT, "probe hit");
        @(posedge CLOCK_IN);
    endtask
    task snoop(input logic w, input logic [33:0] a);
        {SNP_VALID_IN, SNP_WRITE_IN, SNP_ADDR_IN} <= {1'b1, w, a};
        @(posedge CLOCK_IN);
        SNP_VALID_IN <= 1'b0;
        @(posedge CLOCK_IN);
        chk(1'b1, SNP_RSP_VALID_OUT, "snoop answer");
        rsp = SNP_RSP_OUT;
        pinv = {PINV_VALID_OUT, PINV_PAIR_OUT};
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog far beyond the few hundred cycles needed
    initial
    begin
        #1000000;
        bad_count++;
        finish_test;
    end
    // ==========
    // main sequence
    initial
    begin
        {RST_N_IN, AVS_READ_IN, AVS_WRITE_IN, PREQ_VALID_IN, PREQ_WRITE_IN, SNP_VALID_IN} = '0;
        {SNP_WRITE_IN, AVS_ADDRESS_IN, AVS_WRITEDATA_IN, PREQ_ADDR_IN, SNP_ADDR_IN, shared_q, dly_q} = '0;
        bad_count = 0;
        num_checks = 0;
        repeat (8) @(posedge CLOCK_IN);
        chk(1'b0, BREQ_VALID_OUT | PRSP_VALID_OUT | SNP_RSP_VALID_OUT | PINV_VALID_OUT, "reset outputs");
        RST_N_IN <= 1'b1;
        foreach (rows[i])
        begin
            av(1'b0, rows[i].a, 32'h0);
            chk(REG_RST, rd, "reset value");
            av(1'b1, rows[i].a, rows[i].w);
            av(1'b0, rows[i].a, 32'h0);
            chk(rows[i].e, rd, "readback");
        end
        av(1'b1, OFF_MODE, {30'h0, WM_NORMAL});
        probe(1'b0, A, 1'b0);
        chk(CMD_READ, last_cmd, "refill command");
        chk(A, last_adr, "refill address");
        probe(1'b0, A, 1'b1);
        probe(1'b1, A, 1'b1);
        snoop(1'b0, A);
        chk(2'b11, {rsp.dirty, rsp.supply}, "dirty supply");
        shared_q <= 1'b1;
        probe(1'b1, B, 1'b0);
        chk(CMD_WRITE, last_cmd, "broadcast");
        probe(1'b1, B, 1'b0);
        probe(1'b0, B, 1'b1);
        av(1'b1, OFF_MODE, {30'h0, WM_FINV});
        snoop(1'b1, B);
        chk(2'b01, {rsp.update, rsp.inval}, "forced invalidate");
        probe(1'b0, B, 1'b0);
        av(1'b1, OFF_MODE, {30'h0, WM_FUPD});
        snoop(1'b1, B);
        chk({2'b10, 1'b1, B[12:6]}, {rsp.update, rsp.inval, pinv}, "forced update");
        probe(1'b0, B, 1'b1);
        snoop(1'b0, B);
        chk(1'b0, rsp.dirty, "clean after bus write");
        av(1'b1, OFF_MODE, {30'h0, WM_NORMAL});
        shared_q <= 1'b0;
        dly_q <= 4'hf;
        probe(1'b0, C, 1'b0);
        av(1'b0, OFF_VICT, 32'h0);
        chk({1'b1, 3'h0, A[33:6]}, rd, "victim held");
        snoop(1'b0, A);
        chk(1'b1, rsp.vsupply, "victim supply");
        snoop(1'b1, A);
        repeat (20) @(posedge CLOCK_IN);
        av(1'b0, OFF_VICT, 32'h0);
        chk(1'b0, rd[31], "victim dropped");
        chk(CMD_READ, last_cmd, "victim request withdrawn");
        snoop(1'b0, L);
        chk(1'b1, rsp.shared, "lock read shared");
        snoop(1'b1, L);
        av(1'b0, OFF_LOCK, 32'h0);
        chk(32'h0000_0040, rd, "lock flag cleared");
        RST_N_IN <= 1'b0;
        repeat (2) @(posedge CLOCK_IN);
        chk(1'b0, PRSP_VALID_OUT | BREQ_VALID_OUT, "mid-run reset");
        RST_N_IN <= 1'b1;
        probe(1'b0, B, 1'b0);
        finish_test;
    end
endmodule
`default_nettype wire
